// [hw/ssic_control.sv]
// Encoder control block: output image, indirect registers, comparators, polling, APB slave
`timescale 1ns/10ps
`include "ssic_defs.svh"
module ssic_control (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Encoder front end
   input wire logic [31:0] encoder_position_in,
   input wire logic encoder_valid_in,
   output logic poll_request_out,
   // Parameter check result from outside pin
   input wire logic parameter_rejected_in,
   // Status
   output logic polling_halted_out,
   output logic irq_out
);
   // Output image and status state
   logic [31:0] out_image;
   logic [31:0] write_data;
   logic [31:0] read_data;
   logic read_aborted;
   logic write_acknowledge;
   ssic_pkg::ssic_wr_state_t wr_state;
   logic [31:0] regs [0:`SSIC_REG_COUNT-1];
   logic [31:0] encoder_position;
   logic [`SSIC_IRQ_WIDTH-1:0] irq_status;
   logic [`SSIC_IRQ_WIDTH-1:0] irq_mask;
   logic [`SSIC_IRQ_WIDTH-1:0] prev_events;
   logic [2:0] rej_sync;
   logic parameter_rejected;
   logic [15:0] poll_count;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   logic [31:0] next_out_image;
   logic [31:0] next_write_data;
   logic [31:0] next_read_data;
   logic next_read_aborted;
   logic next_write_acknowledge;
   ssic_pkg::ssic_wr_state_t next_wr_state;
   logic [31:0] next_encoder_position;
   logic [`SSIC_IRQ_WIDTH-1:0] next_irq_status;
   logic [`SSIC_IRQ_WIDTH-1:0] next_irq_mask;
   logic [`SSIC_IRQ_WIDTH-1:0] events;
   logic next_parameter_rejected;
   logic [15:0] next_poll_count;
   logic next_poll_request;
   logic next_halted;
   logic next_irq;
   logic write_fire;
   logic [5:0] wr_idx;
   logic [5:0] rd_idx;
   logic stop_request;
   logic apb_access;
   logic apb_setup;
   logic [1:0] cmp_enable;
   logic [1:0] cmp_clear;
   logic [31:0] cmp_reference [0:1];
   logic [1:0] at_or_above;
   logic [1:0] equal_now;
   logic [1:0] sticky_match;

   localparam logic [15:0] POLL_LAST = 16'(`SSIC_POLL_CYCLES - 1);

   // Address decode used only for the slave error response; the read mux and write path compare addresses themselves
   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = (addr == `SSIC_ADDR_OUT_IMAGE) || (addr == `SSIC_ADDR_WRITE_DATA) ||
                    (addr == `SSIC_ADDR_STATUS) || (addr == `SSIC_ADDR_READ_DATA) ||
                    (addr == `SSIC_ADDR_IRQ_STATUS) || (addr == `SSIC_ADDR_IRQ_MASK);
   endfunction : addr_mapped

   // Output image fields
   assign stop_request = out_image[`SSIC_STOP_BIT];
   assign wr_idx = out_image[`SSIC_WR_IDX_LSB +: 6];
   assign rd_idx = out_image[`SSIC_RD_IDX_LSB +: 6];
   assign cmp_enable = {out_image[`SSIC_EN_TWO_BIT], out_image[`SSIC_EN_ONE_BIT]};
   assign cmp_clear = {out_image[`SSIC_CLR_TWO_BIT], out_image[`SSIC_CLR_ONE_BIT]};
   assign cmp_reference[0] = regs[`SSIC_IDX_REF_ONE];
   assign cmp_reference[1] = regs[`SSIC_IDX_REF_TWO];

   assign apb_setup = psel_in && !penable_in;
   assign apb_access = psel_in && penable_in && pready_out;
   // Write fires once per request level
   assign write_fire = out_image[`SSIC_WR_REQ_BIT] && (wr_state == ssic_pkg::SSIC_WR_IDLE);

   // Comparators
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         ssic_compare u_cmp (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .enable_in(cmp_enable[gi]),
            .clear_in(cmp_clear[gi]),
            .position_in(encoder_position),
            .reference_in(cmp_reference[gi]),
            .at_or_above_out(at_or_above[gi]),
            .equal_now_out(equal_now[gi]),
            .sticky_match_out(sticky_match[gi])
         );
      end
   endgenerate

   // Parameter reject pin: three stages, change counts when stages two and three agree
   always_comb begin
      next_parameter_rejected = parameter_rejected;
      if (rej_sync[1] == rej_sync[2]) begin
         next_parameter_rejected = rej_sync[2];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rej_sync <= 3'h0;
         parameter_rejected <= 1'b0;
      end else begin
         rej_sync <= {rej_sync[1:0], parameter_rejected_in};
         parameter_rejected <= next_parameter_rejected;
      end
   end

   // Polling divider and position capture
   always_comb begin
      next_halted = stop_request || parameter_rejected;
      next_poll_count = poll_count;
      next_poll_request = 1'b0;
      next_encoder_position = encoder_position;
      if (next_halted) begin
         next_poll_count = 16'h0000;
      end else if (poll_count == POLL_LAST) begin
         next_poll_count = 16'h0000;
         next_poll_request = 1'b1;
      end else begin
         next_poll_count = poll_count + 16'h0001;
      end
      // Late answers after a stop are dropped so no traffic is honoured while halted
      if (encoder_valid_in && !polling_halted_out && !stop_request) begin
         next_encoder_position = encoder_position_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         poll_count <= 16'h0000;
         poll_request_out <= 1'b0;
         polling_halted_out <= 1'b0;
         encoder_position <= 32'h0000_0000;
      end else begin
         poll_count <= next_poll_count;
         poll_request_out <= next_poll_request;
         polling_halted_out <= next_halted;
         encoder_position <= next_encoder_position;
      end
   end

   // Indirect register write handshake
   always_comb begin
      next_wr_state = wr_state;
      next_write_acknowledge = write_acknowledge;
      case (wr_state)
         ssic_pkg::SSIC_WR_IDLE: begin
            if (write_fire) begin
               next_wr_state = ssic_pkg::SSIC_WR_DONE;
               next_write_acknowledge = 1'b1;
            end
         end
         ssic_pkg::SSIC_WR_DONE: begin
            if (!out_image[`SSIC_WR_REQ_BIT]) begin
               next_wr_state = ssic_pkg::SSIC_WR_IDLE;
               next_write_acknowledge = 1'b0;
            end
         end
         default: begin
            next_wr_state = ssic_pkg::SSIC_WR_IDLE;
            next_write_acknowledge = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_state <= ssic_pkg::SSIC_WR_IDLE;
         write_acknowledge <= 1'b0;
      end else begin
         wr_state <= next_wr_state;
         write_acknowledge <= next_write_acknowledge;
      end
   end

   // Register array has no reset; index 0 mirrors the live position instead
   always_ff @(posedge clk_in) begin
      if (write_fire) begin
         regs[wr_idx] <= write_data;
      end
   end

   // Read-back path; a read colliding with the write in progress is aborted
   always_comb begin
      next_read_aborted = write_fire && (wr_idx == rd_idx);
      next_read_data = read_data;
      if (!next_read_aborted) begin
         if (rd_idx == `SSIC_IDX_POSITION) begin
            next_read_data = encoder_position;
         end else begin
            next_read_data = regs[rd_idx];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         read_data <= 32'h0000_0000;
         read_aborted <= 1'b0;
      end else begin
         read_data <= next_read_data;
         read_aborted <= next_read_aborted;
      end
   end

   // APB slave and interrupt logic
   assign events = {polling_halted_out, write_acknowledge, sticky_match[1], sticky_match[0]};

   always_comb begin
      next_pready = apb_setup && !pready_out;
      next_pslverr = apb_setup && !addr_mapped(paddr_in);
      next_prdata = 32'h0000_0000;
      next_out_image = out_image;
      next_write_data = write_data;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      if (apb_setup && !pwrite_in) begin
         if (paddr_in == `SSIC_ADDR_OUT_IMAGE) begin
            next_prdata = out_image;
         end else if (paddr_in == `SSIC_ADDR_WRITE_DATA) begin
            next_prdata = write_data;
         end else if (paddr_in == `SSIC_ADDR_STATUS) begin
            next_prdata[`SSIC_ST_WR_ACK] = write_acknowledge;
            next_prdata[`SSIC_ST_RD_ABORT] = read_aborted;
            next_prdata[`SSIC_ST_ABOVE_ONE] = at_or_above[0];
            next_prdata[`SSIC_ST_EQUAL_ONE] = equal_now[0];
            next_prdata[`SSIC_ST_STICKY_ONE] = sticky_match[0];
            next_prdata[`SSIC_ST_ABOVE_TWO] = at_or_above[1];
            next_prdata[`SSIC_ST_EQUAL_TWO] = equal_now[1];
            next_prdata[`SSIC_ST_STICKY_TWO] = sticky_match[1];
            next_prdata[`SSIC_ST_HALTED] = polling_halted_out;
            next_prdata[`SSIC_ST_REJECTED] = parameter_rejected;
         end else if (paddr_in == `SSIC_ADDR_READ_DATA) begin
            next_prdata = read_data;
         end else if (paddr_in == `SSIC_ADDR_IRQ_STATUS) begin
            next_prdata[`SSIC_IRQ_WIDTH-1:0] = irq_status;
         end else if (paddr_in == `SSIC_ADDR_IRQ_MASK) begin
            next_prdata[`SSIC_IRQ_WIDTH-1:0] = irq_mask;
         end
      end
      if (apb_access && pwrite_in) begin
         if (paddr_in == `SSIC_ADDR_OUT_IMAGE) begin
            next_out_image = pwdata_in;
         end else if (paddr_in == `SSIC_ADDR_WRITE_DATA) begin
            next_write_data = pwdata_in;
         end else if (paddr_in == `SSIC_ADDR_IRQ_MASK) begin
            next_irq_mask = pwdata_in[`SSIC_IRQ_WIDTH-1:0];
         end
      end
      // Read clears, but a new event in the same cycle survives
      if (apb_access && !pwrite_in && (paddr_in == `SSIC_ADDR_IRQ_STATUS)) begin
         next_irq_status = '0;
      end
      next_irq_status = next_irq_status | (events & ~prev_events);
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         out_image <= `SSIC_OUT_IMAGE_RESET;
         write_data <= 32'h0000_0000;
         irq_mask <= `SSIC_IRQ_MASK_RESET;
         irq_status <= '0;
         prev_events <= '0;
         irq_out <= 1'b0;
      end else begin
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         prdata_out <= next_prdata;
         out_image <= next_out_image;
         write_data <= next_write_data;
         irq_mask <= next_irq_mask;
         irq_status <= next_irq_status;
         prev_events <= events;
         irq_out <= next_irq;
      end
   end
endmodule : ssic_control

// [include/ssic_defs.svh]
// Offsets, field positions, reset values and timing counts for the encoder control block
`ifndef SSIC_DEFS_SVH
`define SSIC_DEFS_SVH
// APB byte addresses
`define SSIC_ADDR_OUT_IMAGE   8'h00
`define SSIC_ADDR_WRITE_DATA  8'h04
`define SSIC_ADDR_STATUS      8'h08
`define SSIC_ADDR_READ_DATA   8'h0C
`define SSIC_ADDR_IRQ_STATUS  8'h10
`define SSIC_ADDR_IRQ_MASK    8'h14
// Output image word: byte 0 stop, byte 1 compare control, byte 2 write, byte 3 read
`define SSIC_STOP_BIT         7
`define SSIC_EN_ONE_BIT       8
`define SSIC_CLR_ONE_BIT      9
`define SSIC_EN_TWO_BIT       11
`define SSIC_CLR_TWO_BIT      12
`define SSIC_WR_IDX_LSB       16
`define SSIC_WR_REQ_BIT       23
`define SSIC_RD_IDX_LSB       24
// Status word
`define SSIC_ST_WR_ACK        0
`define SSIC_ST_RD_ABORT      1
`define SSIC_ST_ABOVE_ONE     2
`define SSIC_ST_EQUAL_ONE     3
`define SSIC_ST_STICKY_ONE    4
`define SSIC_ST_ABOVE_TWO     5
`define SSIC_ST_EQUAL_TWO     6
`define SSIC_ST_STICKY_TWO    7
`define SSIC_ST_HALTED        8
`define SSIC_ST_REJECTED      9
// Interrupt event bits
`define SSIC_IRQ_MATCH_ONE    0
`define SSIC_IRQ_MATCH_TWO    1
`define SSIC_IRQ_WR_ACK       2
`define SSIC_IRQ_HALTED       3
`define SSIC_IRQ_WIDTH        4
// Internal register indices
`define SSIC_IDX_POSITION     6'h00
`define SSIC_IDX_REF_ONE      6'h01
`define SSIC_IDX_REF_TWO      6'h02
`define SSIC_REG_COUNT        64
// Reset values
`define SSIC_OUT_IMAGE_RESET  32'h0000_0000
`define SSIC_IRQ_MASK_RESET   4'h0
// Polling period
`define SSIC_CLK_HZ           10000000
`define SSIC_POLL_US          100
`define SSIC_POLL_CYCLES      ((`SSIC_POLL_US * (`SSIC_CLK_HZ / 1000000)) < 1 ? 1 : \
                               (`SSIC_POLL_US * (`SSIC_CLK_HZ / 1000000)))
`endif

// [include/ssic_pkg.sv]
// Types shared by the encoder control block
package ssic_pkg;
   typedef enum logic {
      SSIC_WR_IDLE,
      SSIC_WR_DONE
   } ssic_wr_state_t;
endpackage : ssic_pkg

// [hw/ssic_compare.sv]
// One position comparator with relation, equality and sticky match outputs
`timescale 1ns/10ps
`include "ssic_defs.svh"
module ssic_compare (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Control
   input wire logic enable_in,
   input wire logic clear_in,
   // Operands
   input wire logic [31:0] position_in,
   input wire logic [31:0] reference_in,
   // Results
   output logic at_or_above_out,
   output logic equal_now_out,
   output logic sticky_match_out
);
   logic next_at_or_above;
   logic next_equal_now;
   logic next_sticky_match;

   always_comb begin
      next_at_or_above = 1'b0;
      next_equal_now = 1'b0;
      next_sticky_match = 1'b0;
      if (enable_in) begin
         next_at_or_above = (position_in >= reference_in);
         next_equal_now = (position_in == reference_in);
         // Clear holds the flag down even against a match
         if (clear_in) begin
            next_sticky_match = 1'b0;
         end else begin
            next_sticky_match = sticky_match_out | (position_in == reference_in);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         at_or_above_out <= 1'b0;
         equal_now_out <= 1'b0;
         sticky_match_out <= 1'b0;
      end else begin
         at_or_above_out <= next_at_or_above;
         equal_now_out <= next_equal_now;
         sticky_match_out <= next_sticky_match;
      end
   end
endmodule : ssic_compare

// [tb/ssic_control_sva.sv]
// Port-level checks for the encoder control block
`timescale 1ns/10ps
`include "ssic_defs.svh"
module ssic_control_sva (
   // Watched top-level ports
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic poll_request_out,
   input wire logic parameter_rejected_in,
   input wire logic polling_halted_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic [10:0] poll_gap;
   logic [10:0] next_poll_gap;
   // Counter restarts while halted, since polling may legally resume on a fresh period
   always_comb begin
      next_poll_gap = poll_gap + 11'h001;
      if (poll_request_out || polling_halted_out) next_poll_gap = 11'h000;
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) poll_gap <= 11'h000;
      else poll_gap <= next_poll_gap;
   end
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_stop_write;
      psel_in && penable_in && pready_out && pwrite_in && paddr_in == `SSIC_ADDR_OUT_IMAGE && pwdata_in[`SSIC_STOP_BIT];
   endsequence
   sequence s_reject_held;
      parameter_rejected_in [*6];
   endsequence
   AST_SETUP_ANSWERED: assert property (s_setup |=> pready_out) else $error("setup not answered");
   AST_READY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready held");
   AST_IDLE_QUIET: assert property (!psel_in |=> !pready_out && !pslverr_out) else $error("idle answer");
   AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out) else $error("error without ready");
   AST_UNMAPPED_REFUSED: assert property (s_setup and paddr_in > 8'h14 |=> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped accepted");
   AST_IMAGE_MAPPED: assert property (s_setup and paddr_in == `SSIC_ADDR_OUT_IMAGE |=> !pslverr_out)
      else $error("image refused");
   AST_STOP_HALTS: assert property (s_stop_write |-> ##[1:2] polling_halted_out) else $error("stop ignored");
   AST_REJECT_HALTS: assert property (s_reject_held |-> polling_halted_out) else $error("reject ignored");
   AST_HALTED_NO_POLL: assert property (polling_halted_out && $past(polling_halted_out) |-> !poll_request_out)
      else $error("poll while halted");
   AST_POLL_PERIOD: assert property (poll_gap < 11'h3EA) else $error("poll overdue");
   AST_POLL_GAP: assert property (poll_request_out |=> !poll_request_out [*8]) else $error("poll too soon");
endmodule : ssic_control_sva
bind ssic_control ssic_control_sva i_ssic_control_sva (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .poll_request_out(poll_request_out), .parameter_rejected_in(parameter_rejected_in),
   .polling_halted_out(polling_halted_out));

// [tb/ssic_encoder_model.sv]
// Encoder front end stand-in: answers each poll with a position word
`timescale 1ns/10ps
module ssic_encoder_model (
   // Clock and polling
   input wire logic clk_in,
   input wire logic poll_request_in,
   // Behaviour chosen by the bench
   input wire logic [31:0] target_in,
   input wire logic slow_in,
   // Answer
   output logic encoder_valid_out,
   output logic [31:0] encoder_position_out
);
   int wait_cnt = -1;
   initial begin
      encoder_valid_out = 1'b0;
      encoder_position_out = 32'h5A5A_A5A5;
   end
   // Word toggles outside answers so stale data never looks fresh
   always @(posedge clk_in) begin
      encoder_valid_out <= 1'b0;
      encoder_position_out <= ~encoder_position_out;
      if (poll_request_in) wait_cnt <= slow_in ? 40 : 2;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 0) begin
         encoder_valid_out <= 1'b1;
         encoder_position_out <= target_in;
         wait_cnt <= -1;
      end
   end
endmodule : ssic_encoder_model

// [tb/tb_top.sv]
// Self-checking bench for the encoder control block
`timescale 1ns/10ps
`include "ssic_defs.svh"
module tb_top;
   localparam int EN_B [2] = '{`SSIC_EN_ONE_BIT, `SSIC_EN_TWO_BIT};
   localparam int CLR_B [2] = '{`SSIC_CLR_ONE_BIT, `SSIC_CLR_TWO_BIT};
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic parameter_rejected_in = 1'b0;
   logic slow = 1'b0;
   logic [31:0] target = 32'h0000_0000;
   logic [31:0] prdata_out, encoder_position_in, rd, image, ref_val;
   logic pready_out, pslverr_out, poll_request_out, polling_halted_out, irq_out, encoder_valid_in, err;
   int n_mismatch = 0;
   int samples_checked = 0;
   int polls;
   logic [31:0] mdl_reg [64];
   bit [1:0] mdl_sticky;
   always #50 clk_in = ~clk_in;
   ssic_control i_ssic_control (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .encoder_position_in(encoder_position_in),
      .encoder_valid_in(encoder_valid_in), .poll_request_out(poll_request_out),
      .parameter_rejected_in(parameter_rejected_in), .polling_halted_out(polling_halted_out), .irq_out(irq_out));
   ssic_encoder_model i_ssic_encoder_model (.clk_in(clk_in), .poll_request_in(poll_request_out),
      .target_in(target), .slow_in(slow), .encoder_valid_out(encoder_valid_in),
      .encoder_position_out(encoder_position_in));
   task automatic conclude();
      $display("TB: %0d compares, %0d mismatches", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         k++;
      end while (pready_out !== 1'b1 && k < 16);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (pready_out !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(exp & m, rd & m);
   endtask : rdchk
   task automatic img();
      apb(1'b1, `SSIC_ADDR_OUT_IMAGE, image);
   endtask : img
   function automatic logic [31:0] exp_st();
      logic [31:0] s;
      s = 32'h0000_0000;
      for (int n = 0; n < 2; n++) begin
         if (image[EN_B[n]]) begin
            s[2 + 3 * n] = target >= mdl_reg[n + 1];
            s[3 + 3 * n] = target == mdl_reg[n + 1];
            s[4 + 3 * n] = mdl_sticky[n];
         end
      end
      return s;
   endfunction : exp_st
   task automatic settle();
      cyc(3);
      for (int n = 0; n < 2; n++) begin
         if (!image[EN_B[n]] || image[CLR_B[n]]) mdl_sticky[n] = 1'b0;
         else if (target == mdl_reg[n + 1]) mdl_sticky[n] = 1'b1;
      end
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_00FC, exp_st());
   endtask : settle
   task automatic set_pos(input logic [31:0] v);
      int k;
      k = 0;
      target <= v;
      // An answer launched on this same edge still carries the old target
      do begin
         @(posedge clk_in);
         k++;
      end while ((encoder_valid_in !== 1'b1 || encoder_position_in !== v) && k < 1200);
      if (encoder_valid_in !== 1'b1 || encoder_position_in !== v) begin
         n_mismatch++;
         conclude();
      end
      settle();
   endtask : set_pos
   task automatic reg_write(input logic [5:0] idx, input logic [31:0] val);
      apb(1'b1, `SSIC_ADDR_WRITE_DATA, val);
      image[`SSIC_WR_IDX_LSB +: 6] = idx;
      image[`SSIC_WR_REQ_BIT] = 1'b1;
      img();
      mdl_reg[idx] = val;
      cyc(3);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      apb(1'b1, `SSIC_ADDR_WRITE_DATA, ~val);
      cyc(3);
      image[`SSIC_WR_REQ_BIT] = 1'b0;
      img();
      cyc(3);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
      image[`SSIC_RD_IDX_LSB +: 6] = idx;
      img();
      rdchk(`SSIC_ADDR_READ_DATA, 32'hFFFF_FFFF, mdl_reg[idx]);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_0002, 32'h0000_0000);
   endtask : reg_write
   initial begin
      void'($urandom(32'h1EEBD2FE));
      image = 32'h0000_0000;
      mdl_sticky = 2'b00;
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      rdchk(`SSIC_ADDR_OUT_IMAGE, 32'hFFFF_FFFF, 32'h0000_0000);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_03FF, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk(32'h0000_0001, {31'h0, err});
      $display("TEST reset done");
      reg_write(6'($urandom_range(62, 3)), $urandom);
      reg_write(6'h3F, $urandom);
      $display("TEST indirect done");
      for (int n = 0; n < 2; n++) begin
         slow <= (n == 1);
         ref_val = ($urandom & 32'h3FFF_FFF0) | 32'h0000_0100;
         reg_write(6'(n + 1), ref_val);
         image[EN_B[n]] = 1'b1;
         img();
         set_pos(ref_val - 1);
         set_pos(ref_val);
         set_pos(ref_val + 1);
         set_pos(ref_val - 1);
         image[CLR_B[n]] = 1'b1;
         img();
         settle();
         set_pos(ref_val);
         image[CLR_B[n]] = 1'b0;
         img();
         settle();
         image[EN_B[n]] = 1'b0;
         img();
         settle();
         $display("TEST compare %0d done", n);
      end
      image[`SSIC_STOP_BIT] = 1'b1;
      img();
      cyc(3);
      chk(32'h0000_0001, {31'h0, polling_halted_out});
      polls = 0;
      repeat (1100) @(posedge clk_in) polls += (poll_request_out === 1'b1);
      chk(32'h0000_0000, polls);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_0100, 32'h0000_0100);
      image[`SSIC_STOP_BIT] = 1'b0;
      img();
      polls = 0;
      repeat (1100) @(posedge clk_in) polls += (poll_request_out === 1'b1);
      chk(32'h0000_0001, {31'h0, polls > 0});
      parameter_rejected_in <= 1'b1;
      cyc(8);
      rdchk(`SSIC_ADDR_STATUS, 32'h0000_0300, 32'h0000_0300);
      parameter_rejected_in <= 1'b0;
      cyc(8);
      chk(32'h0000_0000, {31'h0, polling_halted_out});
      $display("TEST halt done");
      apb(1'b1, `SSIC_ADDR_IRQ_MASK, 32'h0000_0000);
      image[EN_B[0]] = 1'b1;
      image[CLR_B[0]] = 1'b1;
      img();
      image[CLR_B[0]] = 1'b0;
      img();
      apb(1'b0, `SSIC_ADDR_IRQ_STATUS, 32'h0000_0000);
      set_pos(mdl_reg[1]);
      chk(32'h0000_0000, {31'h0, irq_out});
      apb(1'b1, `SSIC_ADDR_IRQ_MASK, 32'h0000_0001);
      rdchk(`SSIC_ADDR_IRQ_MASK, 32'h0000_000F, 32'h0000_0001);
      chk(32'h0000_0001, {31'h0, irq_out});
      rdchk(`SSIC_ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      cyc(2);
      chk(32'h0000_0000, {31'h0, irq_out});
      $display("TEST irq done");
      conclude();
   end
endmodule : tb_top
